// ### rtl/mmtc_regs.vh
// Register map, field positions, reset values and mode codes of the timer/counter block
`ifndef MMTC_REGS_VH
`define MMTC_REGS_VH
// Word byte offsets
`define MMTC_A_CTRL 8'h00
`define MMTC_A_CNT 8'h04
`define MMTC_A_RLD 8'h08
`define MMTC_B_CTRL 8'h0c
`define MMTC_B_CNT 8'h10
`define MMTC_B_RLD 8'h14
`define MMTC_IRQ_STAT 8'h18
`define MMTC_IRQ_MASK 8'h1c
`define MMTC_A_STAT 8'h20
// First-group control fields
`define MMTC_CTRL_START 0
`define MMTC_CTRL_MODE_LO 1
`define MMTC_CTRL_MODE_HI 2
`define MMTC_CTRL_UP 3
`define MMTC_CTRL_FREE 4
// Operation modes
`define MMTC_MODE_TIMER 2'h0
`define MMTC_MODE_EVENT 2'h1
`define MMTC_MODE_ONESHOT 2'h2
`define MMTC_MODE_PWM 2'h3
// Interrupt status bits
`define MMTC_IRQ_A 0
`define MMTC_IRQ_B 1
// Reset value and fixed reload-instant read values
`define MMTC_CNT_RST 16'hffff
`define MMTC_ALL_ONES 16'hffff
`define MMTC_ALL_ZERO 16'h0000
`endif

// ### rtl/mmtc_timer.v
// Two reloadable 16-bit timer/counters with a classic Wishbone register slave
//
// Overview of operation
// - Group A timer read: live count, FFFF at reload
// - Halted write to A reads back before start
// - Event reload read: FFFF underflow, 0000 overflow
// - One-shot stop: halt, reload, pin low, interrupt
// - Entering one-shot from reset/timer/event raises request
// - Entering modulation from reset/timer/event raises request
// - Modulation stop with pin high: low, interrupt
// - Modulation stop with pin low: nothing changes
// - Group B timer read: live count, FFFF at reload
// - Halted write to B reads back before start
//
// Register map (byte offsets, 32-bit words, data in bits 15:0)
//   00 first group control: start b0, mode b2:1, up b3, free-run b4
//   04 first group count; a write also loads the reload value
//   08 first group reload value
//   0c second group control: start b0
//   10 second group count; a write also loads the reload value
//   14 second group reload value
//   18 interrupt status: first group b0, second group b1; a read clears
//   1c interrupt mask, same layout as the status word
//   20 first group status: pulse output pin level in b0
//   Anything else, aligned or not, is acknowledged, reads zero and ignores writes
//
// Modes of the first group
//   0 timer: counts down on every clock, reloads after zero
//   1 event counter: counts each rising edge of event_in, up or down
//   2 one-shot: pin high from start until the count runs out
//   3 modulation: pin toggles at every period end
//
// Bus timing
//   A request is taken at the first edge with cyc and stb high and ack low.
//   A write lands at that edge and ack rises with it for exactly one cycle.
//   Read data is registered at the same edge and holds until the next read.
//   The master must drop cyc and stb after ack; a held request would be taken
//   again two cycles later.
//
// Reload instant
//   The cycle after a counter passes its end value is flagged, and a count read
//   taken then shows the fixed wrapped value (FFFF counting down, 0000 counting up) instead of the freshly reloaded count.
//   This keeps software from mistaking a wrapped count for a short period.
//
// Interrupts
//   Status bits are sticky; a read of the status word returns and clears them.
//   An event in the same cycle as that read is kept, so no event is lost.
//   irq is high while any status bit is set under a set mask bit.
//   Entering one-shot or modulation from reset, timer or event mode sets the
//   first group bit on its own; software clears it before relying on it.
//
// Reset
//   nrst is asynchronous and active low. Counters and reload values come up
//   all ones, both groups stopped, first group in timer mode, pin low.
//
// Limitations
//   Byte lanes 2 and 3 are ignored; the upper half of every word reads zero.
//   The second group runs in timer mode only.
//   Modulation is a plain toggle per period with no separate duty value.
//   Event inputs must already be synchronous to sys_clk and last a clock.
//   Event counting in reload type restarts from the reload value;
//   free-run type wraps through the full range instead.
`timescale 1ns/1ps
`include "mmtc_regs.vh"

module mmtc_timer #(
  parameter CW = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // Event input and pulse output
  input wire event_in,
  output reg pulse_output_pin,
  // Interrupt
  output wire irq
);

  // Bus request decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire lo_en = wb_sel_i[0];
  wire hi_en = wb_sel_i[1];
  wire map_hit = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i <= `MMTC_A_STAT);

  // sixteen-bit counters
  // Count and reload registers span the whole CW width
  // Group A control and data
  reg a_start;
  reg [1:0] a_mode;
  reg a_up;
  reg a_free;
  reg [CW-1:0] a_cnt;
  reg [CW-1:0] a_rld;
  reg a_reload_now;
  reg a_reload_ovf;
  reg mode_seen;
  reg ev_prev;
  // Group B
  reg b_start;
  reg [CW-1:0] b_cnt;
  reg [CW-1:0] b_rld;
  reg b_reload_now;
  // Interrupts
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;

  wire ev_rise = event_in & ~ev_prev;
  wire [1:0] wr_mode = wb_dat_i[`MMTC_CTRL_MODE_HI:`MMTC_CTRL_MODE_LO];
  wire a_ctrl_wr = wr && wb_adr_i == `MMTC_A_CTRL && lo_en;
  wire a_stop = a_ctrl_wr && a_start && !wb_dat_i[`MMTC_CTRL_START];
  wire a_cnt_wr = wr && wb_adr_i == `MMTC_A_CNT;
  wire b_cnt_wr = wr && wb_adr_i == `MMTC_B_CNT;
  wire a_tick_mode = (a_mode != `MMTC_MODE_EVENT);
  wire a_step = a_start && (a_tick_mode || ev_rise);
  wire a_down = (a_mode != `MMTC_MODE_EVENT) || !a_up;
  wire a_at_end = a_down ? (a_cnt == {CW{1'b0}}) : (a_cnt == {CW{1'b1}});
  wire b_at_end = (b_cnt == {CW{1'b0}});

  // Entering one-shot or modulation from reset, timer or event mode
  wire a_pseudo_req = a_ctrl_wr &&
    (wr_mode == `MMTC_MODE_ONESHOT || wr_mode == `MMTC_MODE_PWM) &&
    (!mode_seen || a_mode == `MMTC_MODE_TIMER || a_mode == `MMTC_MODE_EVENT);

  // Counting events; stop of a modulation output only counts while pin high
  wire a_pwm_stop_ev = a_stop && a_mode == `MMTC_MODE_PWM && pulse_output_pin;
  wire a_os_stop_ev = a_stop && a_mode == `MMTC_MODE_ONESHOT;
  wire a_end_ev = a_step && a_at_end;
  wire a_event = a_end_ev || a_pseudo_req || a_pwm_stop_ev || a_os_stop_ev;
  wire b_event = b_start && b_at_end;

  // Group A control register
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_start <= 1'b0;
      a_mode <= `MMTC_MODE_TIMER;
      a_up <= 1'b0;
      a_free <= 1'b0;
      mode_seen <= 1'b0;
      ev_prev <= 1'b0;
    end else begin
      ev_prev <= event_in;
      if (a_ctrl_wr) begin
        a_start <= wb_dat_i[`MMTC_CTRL_START];
        a_mode <= wr_mode;
        a_up <= wb_dat_i[`MMTC_CTRL_UP];
        a_free <= wb_dat_i[`MMTC_CTRL_FREE];
        mode_seen <= 1'b1;
      end else if (a_end_ev && a_mode == `MMTC_MODE_ONESHOT) begin
        // One-shot ends by itself after one period
        a_start <= 1'b0;
      end
    end
  end

  // Group A counter; a full-width write always lands, halted or not
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      a_cnt <= `MMTC_CNT_RST;
      a_rld <= `MMTC_CNT_RST;
      a_reload_now <= 1'b0;
      a_reload_ovf <= 1'b0;
    end else begin
      a_reload_now <= 1'b0;
      if (wr && wb_adr_i == `MMTC_A_RLD) begin
        if (lo_en) a_rld[7:0] <= wb_dat_i[7:0];
        if (hi_en) a_rld[15:8] <= wb_dat_i[15:8];
      end
      if (a_cnt_wr) begin
        if (lo_en) a_cnt[7:0] <= wb_dat_i[7:0];
        if (hi_en) a_cnt[15:8] <= wb_dat_i[15:8];
        if (lo_en) a_rld[7:0] <= wb_dat_i[7:0];
        if (hi_en) a_rld[15:8] <= wb_dat_i[15:8];
      end else if (a_os_stop_ev) begin
        a_cnt <= a_rld;
      end else if (a_end_ev) begin
        a_reload_now <= 1'b1;
        a_reload_ovf <= !a_down;
        // Free-run wraps through; reload type restarts from the reload value
        if (a_mode == `MMTC_MODE_EVENT && a_free)
          a_cnt <= a_down ? {CW{1'b1}} : {CW{1'b0}};
        else
          a_cnt <= a_rld;
      end else if (a_step) begin
        a_cnt <= a_down ? a_cnt - 1'b1 : a_cnt + 1'b1;
      end
    end
  end

  // Pulse output: high while a one-shot runs, toggles each modulation period
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_output_pin <= 1'b0;
    end else if (a_stop) begin
      // modulation stop drives low; keeps a low pin low
      pulse_output_pin <= 1'b0;
    end else if (a_ctrl_wr && wb_dat_i[`MMTC_CTRL_START] && !a_start &&
                 wr_mode == `MMTC_MODE_ONESHOT) begin
      pulse_output_pin <= 1'b1;
    end else if (a_end_ev && a_mode == `MMTC_MODE_ONESHOT) begin
      pulse_output_pin <= 1'b0;
    end else if (a_end_ev && a_mode == `MMTC_MODE_PWM) begin
      pulse_output_pin <= ~pulse_output_pin;
    end
  end

  // Group B timer
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      b_start <= 1'b0;
      b_cnt <= `MMTC_CNT_RST;
      b_rld <= `MMTC_CNT_RST;
      b_reload_now <= 1'b0;
    end else begin
      b_reload_now <= 1'b0;
      if (wr && wb_adr_i == `MMTC_B_CTRL && lo_en)
        b_start <= wb_dat_i[`MMTC_CTRL_START];
      if (wr && wb_adr_i == `MMTC_B_RLD) begin
        if (lo_en) b_rld[7:0] <= wb_dat_i[7:0];
        if (hi_en) b_rld[15:8] <= wb_dat_i[15:8];
      end
      if (b_cnt_wr) begin
        if (lo_en) b_cnt[7:0] <= wb_dat_i[7:0];
        if (hi_en) b_cnt[15:8] <= wb_dat_i[15:8];
        if (lo_en) b_rld[7:0] <= wb_dat_i[7:0];
        if (hi_en) b_rld[15:8] <= wb_dat_i[15:8];
      end else if (b_event) begin
        b_reload_now <= 1'b1;
        b_cnt <= b_rld;
      end else if (b_start) begin
        b_cnt <= b_cnt - 1'b1;
      end
    end
  end

  // Sticky status; a read clears, but an event in the same cycle wins
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      if (wr && wb_adr_i == `MMTC_IRQ_MASK && lo_en)
        irq_mask <= wb_dat_i[1:0];
      irq_stat <= ((rd && wb_adr_i == `MMTC_IRQ_STAT) ? 2'h0 : irq_stat) |
                  {b_event, a_event};
    end
  end

  assign irq = |(irq_stat & irq_mask);
  assign wb_err_o = 1'b0;

  // Read data, registered; the reload instant shows the fixed value
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd && !map_hit) begin
        // Unaligned or out-of-map reads answer zero
        wb_dat_o <= 32'h0000_0000;
      end else if (rd) begin
        case (wb_adr_i)
          `MMTC_A_CTRL: wb_dat_o <= {27'h0, a_free, a_up, a_mode, a_start};
          `MMTC_A_CNT: wb_dat_o <= {16'h0, a_reload_now ?
            (a_reload_ovf ? `MMTC_ALL_ZERO : `MMTC_ALL_ONES) : a_cnt};
          `MMTC_A_RLD: wb_dat_o <= {16'h0, a_rld};
          `MMTC_B_CTRL: wb_dat_o <= {31'h0, b_start};
          `MMTC_B_CNT: wb_dat_o <= {16'h0, b_reload_now ? `MMTC_ALL_ONES : b_cnt};
          `MMTC_B_RLD: wb_dat_o <= {16'h0, b_rld};
          `MMTC_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat};
          `MMTC_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask};
          `MMTC_A_STAT: wb_dat_o <= {31'h0, pulse_output_pin};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end


endmodule

// ### sim/mmtc_chk.sv
// Port checker for the timer/counter block
`timescale 1ns/1ps
`include "mmtc_regs.vh"
module mmtc_chk (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire wb_err_o,
  // Pin and interrupt
  input wire pulse_output_pin,
  input wire irq
);
  // Request taken, and a stop written in one-shot or modulation mode
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire stop_a = take && wb_we_i && wb_adr_i == `MMTC_A_CTRL && wb_dat_i[2] && !wb_dat_i[0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_ack_next: assert property (take |=> wb_ack_o) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_err_low: assert property (!wb_err_o) else $error("err raised");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (take && !wb_we_i && wb_adr_i == 8'h24 |=> wb_dat_o == 0)
    else $error("unmapped read not zero");
  // Read data may only move on the answer to a read
  a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data moved");
  a_stop_pin_low: assert property (stop_a |-> ##[1:2] !pulse_output_pin)
    else $error("pin high after stop");
  a_stop_low_stays: assert property (stop_a && !pulse_output_pin |=> !pulse_output_pin [*2])
    else $error("pin rose at stop");
  // Main scenarios reached
  c_stop_high: cover property (stop_a && pulse_output_pin);
  c_pin_rise: cover property ($rose(pulse_output_pin));
  c_irq_rise: cover property ($rose(irq));
endmodule
bind mmtc_timer mmtc_chk u_chk (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .pulse_output_pin(pulse_output_pin),
  .irq(irq)
);

// ### sim/mmtc_evt_src.sv
// Model of the external event source
`timescale 1ns/1ps
module mmtc_evt_src (
  // Clock
  input wire sys_clk,
  // Event line
  output reg event_in
);
  initial event_in = 1'b0;
  // Pulses last two clocks, with two low clocks before the next one
  task send(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        event_in <= 1'b1;
        repeat (2) @(posedge sys_clk);
        event_in <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end
    end
  endtask
endmodule

// ### sim/tb.sv
// Testbench for the timer/counter block
`timescale 1ns/1ps
`include "mmtc_regs.vh"
module tb;
  reg sys_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'h3;
  reg [31:0] wb_dat_i = 32'h0, rdat;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, wb_err_o, event_in, pulse_output_pin, irq;
  integer error_cnt = 0, samples_checked = 0;
  mmtc_timer u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .event_in(event_in),
    .pulse_output_pin(pulse_output_pin), .irq(irq)
  );
  mmtc_evt_src u_src (.sys_clk(sys_clk), .event_in(event_in));
  always #20 sys_clk = ~sys_clk;
  // One classic cycle; holds until ack is seen at an edge
  task bus(input w, input [7:0] a, input [15:0] d);
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
      wb_dat_i <= {16'h0000, d};
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge sys_clk);
    end
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] exp);
    begin
      bus(0, a, 16'h0000);
      chk(nm, exp, rdat);
    end
  endtask
  task t_irq_modes;
    integer i;
    begin
      bus(1, `MMTC_A_CTRL, 16'h0004);
      chk("irq_masked", 0, irq);
      bus(1, `MMTC_IRQ_MASK, 16'h0001);
      chk("irq_on", 1, irq);
      rchk("stat_reset", `MMTC_IRQ_STAT, 1);
      chk("irq_off", 0, irq);
      // From timer and event mode into one-shot and modulation
      for (i = 0; i < 4; i = i + 1) begin
        bus(1, `MMTC_A_CTRL, i[0] ? 16'h0002 : 16'h0000);
        bus(1, `MMTC_A_CTRL, i[1] ? 16'h0006 : 16'h0004);
        rchk("stat_mode", `MMTC_IRQ_STAT, 1);
      end
    end
  endtask
  task t_halt_read;
    begin
      bus(1, `MMTC_A_CNT, 16'ha5c3);
      rchk("a_halt", `MMTC_A_CNT, 32'ha5c3);
      bus(1, `MMTC_B_CNT, 16'h5a3c);
      rchk("b_halt", `MMTC_B_CNT, 32'h5a3c);
      rchk("unmapped", 8'h24, 0);
    end
  endtask
  task t_live;
    begin
      bus(1, `MMTC_A_CTRL, 16'h0001);
      bus(1, `MMTC_B_CTRL, 16'h0001);
      bus(0, `MMTC_A_CNT, 16'h0000);
      chk("a_live", 1, rdat < 32'ha5c3);
      bus(0, `MMTC_B_CNT, 16'h0000);
      chk("b_live", 1, rdat < 32'h5a3c);
      bus(1, `MMTC_A_CTRL, 16'h0000);
      bus(1, `MMTC_B_CTRL, 16'h0000);
    end
  endtask
  // Period of four clocks, reads three clocks apart: every phase is hit
  task t_reload_read;
    integer i, hits_a, hits_b;
    begin
      hits_a = 0;
      hits_b = 0;
      bus(1, `MMTC_A_CNT, 16'h0003);
      bus(1, `MMTC_B_CNT, 16'h0003);
      bus(1, `MMTC_A_CTRL, 16'h0001);
      bus(1, `MMTC_B_CTRL, 16'h0001);
      for (i = 0; i < 8; i = i + 1) begin
        bus(0, `MMTC_A_CNT, 16'h0000);
        if (rdat === 32'hffff) hits_a = hits_a + 1;
        else chk("a_range", 1, rdat <= 32'h0003);
      end
      for (i = 0; i < 8; i = i + 1) begin
        bus(0, `MMTC_B_CNT, 16'h0000);
        if (rdat === 32'hffff) hits_b = hits_b + 1;
        else chk("b_range", 1, rdat <= 32'h0003);
      end
      chk("a_reload_ffff", 1, hits_a > 0);
      chk("b_reload_ffff", 1, hits_b > 0);
      bus(1, `MMTC_A_CTRL, 16'h0000);
      bus(1, `MMTC_B_CTRL, 16'h0000);
    end
  endtask
  // The read is taken one edge after the counted edge, at the reload instant
  task t_event_reload;
    begin
      bus(1, `MMTC_A_CNT, 16'h0000);
      bus(1, `MMTC_A_CTRL, 16'h0003);
      fork
        u_src.send(1);
        begin
          @(posedge sys_clk);
          bus(0, `MMTC_A_CNT, 16'h0000);
        end
      join
      chk("evt_underflow", 32'hffff, rdat);
      bus(1, `MMTC_A_CTRL, 16'h0002);
      bus(1, `MMTC_A_CNT, 16'hffff);
      bus(1, `MMTC_A_CTRL, 16'h000b);
      fork
        u_src.send(1);
        begin
          @(posedge sys_clk);
          bus(0, `MMTC_A_CNT, 16'h0000);
        end
      join
      chk("evt_overflow", 32'h0000, rdat);
      bus(1, `MMTC_A_CTRL, 16'h000a);
    end
  endtask
  // Free-run type driven as software must: preload, start, rewrite, switch
  task t_free;
    begin
      bus(1, `MMTC_A_CNT, 16'h0100);
      bus(1, `MMTC_A_CTRL, 16'h000b);
      bus(1, `MMTC_A_CNT, 16'h0000);
      u_src.send(1);
      bus(1, `MMTC_A_CTRL, 16'h001b);
      u_src.send(2);
      rchk("free_cnt", `MMTC_A_CNT, 32'h0003);
      bus(1, `MMTC_A_CTRL, 16'h001a);
      bus(1, `MMTC_A_CNT, 16'h0000);
      bus(1, `MMTC_A_CTRL, 16'h001b);
      u_src.send(1);
      rchk("free_restart", `MMTC_A_CNT, 32'h0001);
      bus(1, `MMTC_A_CTRL, 16'h000a);
    end
  endtask
  task t_event;
    begin
      bus(1, `MMTC_A_CNT, 16'h0010);
      bus(1, `MMTC_A_CTRL, 16'h0003);
      u_src.send(3);
      rchk("evt_cnt", `MMTC_A_CNT, 32'h000d);
      bus(1, `MMTC_A_CTRL, 16'h0002);
    end
  endtask
  task t_oneshot;
    begin
      bus(1, `MMTC_A_CNT, 16'h0200);
      bus(1, `MMTC_A_CTRL, 16'h0004);
      bus(0, `MMTC_IRQ_STAT, 16'h0000);
      bus(1, `MMTC_A_CTRL, 16'h0005);
      rchk("os_pin", `MMTC_A_STAT, 1);
      bus(1, `MMTC_A_CTRL, 16'h0004);
      chk("os_pin_low", 0, pulse_output_pin);
      chk("os_irq", 1, irq);
      rchk("os_reload", `MMTC_A_CNT, 32'h0200);
      rchk("os_stat", `MMTC_IRQ_STAT, 1);
    end
  endtask
  task t_pwm;
    begin
      bus(1, `MMTC_A_CNT, 16'h0040);
      bus(1, `MMTC_A_CTRL, 16'h0006);
      bus(0, `MMTC_IRQ_STAT, 16'h0000);
      bus(1, `MMTC_A_CTRL, 16'h0007);
      bus(1, `MMTC_A_CTRL, 16'h0006);
      chk("pwm_low", 0, pulse_output_pin);
      rchk("pwm_stat0", `MMTC_IRQ_STAT, 0);
      bus(1, `MMTC_A_CTRL, 16'h0007);
      while (pulse_output_pin !== 1'b1) @(posedge sys_clk);
      rchk("pwm_clear", `MMTC_IRQ_STAT, 1);
      chk("pwm_high", 1, pulse_output_pin);
      bus(1, `MMTC_A_CTRL, 16'h0006);
      chk("pwm_fall", 0, pulse_output_pin);
      rchk("pwm_stat1", `MMTC_IRQ_STAT, 1);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog sized well beyond the whole sequence
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_irq_modes;
    t_halt_read;
    t_live;
    t_reload_read;
    t_event;
    t_event_reload;
    t_free;
    t_oneshot;
    t_pwm;
    report_and_stop;
  end
endmodule
